// *** spio_ext.sv ***
// spio_ext: external circuitry wired to the six general purpose pins
// assumes: the port drives a pin only while its active-low enable is low
`timescale 1ns/100ps

module spio_ext
  import spio_pkg::*;
(
  // port side
  input  wire spio_pkg::spio_pin_drive_t drive,
  // far side
  input  wire logic [spio_pkg::PIN_COUNT-1:0] ext_level,
  output logic [spio_pkg::PIN_COUNT-1:0]      pin_level
);
  // ==========================================================================
  // wire level: port drive wins, otherwise the far side drives the pin
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pin_level[i] = drive.oe_n[i] ? ext_level[i] : drive.level[i];
    end
  end
endmodule : spio_ext

// *** spio_pkg.sv ***
// spio_pkg: constants and types for the six-pin general purpose port
// assumes: a 32-bit register bus with one register per aligned word
package spio_pkg;

  // ==========================================================================
  // bus and port geometry
  localparam int unsigned APB_ADDR_W = 8;
  localparam int unsigned APB_DATA_W = 32;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned PIN_COUNT  = 6;

  // ==========================================================================
  // register indices as printed, byte address is four times the index
  localparam logic [APB_ADDR_W-1:0] IO_PORT_VALUE_IDX    = 8'h33;
  localparam logic [APB_ADDR_W-1:0] IO_PIN_DIRECTION_IDX = 8'h34;
  localparam logic [APB_ADDR_W-1:0] IO_PORT_VALUE_ADDR =
    APB_ADDR_W'(IO_PORT_VALUE_IDX << 2);
  localparam logic [APB_ADDR_W-1:0] IO_PIN_DIRECTION_ADDR =
    APB_ADDR_W'(IO_PIN_DIRECTION_IDX << 2);

  // ==========================================================================
  // field layout and reset values
  localparam int unsigned PIN_FIELD_LSB = 0;
  localparam int unsigned PIN_FIELD_MSB = 5;
  localparam logic [PIN_COUNT-1:0] IO_PORT_VALUE_RESET    = 6'h00;
  localparam logic [PIN_COUNT-1:0] IO_PIN_DIRECTION_RESET = 6'h00;
  localparam logic [PIN_COUNT-1:0] PIN_ALL_RELEASED       = 6'h3F;
  localparam logic [PIN_COUNT-1:0] PIN_ALL_ZERO           = 6'h00;
  localparam logic [APB_DATA_W-1:0] RDATA_ZERO            = 32'h00000000;

  // ==========================================================================
  // register selection result of an address decode
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_PORT,
    SEL_DIR
  } spio_sel_t;

  // pin drive group: level to drive and active-low output enable
  typedef struct packed {
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] oe_n;
  } spio_pin_drive_t;

  // whole state of the port block
  typedef struct packed {
    logic [PIN_COUNT-1:0]  port_value;
    logic [PIN_COUNT-1:0]  direction;
    logic [PIN_COUNT-1:0]  pin_meta;
    logic [PIN_COUNT-1:0]  pin_sync;
    logic [APB_DATA_W-1:0] rdata;
    logic                  slverr;
  } spio_state_t;

  localparam spio_state_t STATE_RESET = '{
    port_value: IO_PORT_VALUE_RESET,
    direction:  IO_PIN_DIRECTION_RESET,
    pin_meta:   PIN_ALL_ZERO,
    pin_sync:   PIN_ALL_ZERO,
    rdata:      RDATA_ZERO,
    slverr:     1'b0
  };

endpackage : spio_pkg

// *** spio_top.sv ***
// spio_top: six-pin general purpose port with value and direction registers
// assumes: an APB master on CLK; pins come from outside and are synchronised
// hazard: a pin change needs two synchroniser edges before a read sees it
// limit: bits 7..6 are dropped on write and always read back as zero
//
// How it works
// - port value register at index 0x33, bits 5..0 map to pins 5..0.
// - direction register at index 0x34, one bit per pin in bits 5..0.
// - a direction bit of one makes the pin output, zero makes it input.
// - reset clears every direction bit, so all pins start as inputs.
// - direction bits are readable and writable, reads return last written.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps

module spio_top (
  // clock and reset
  input  wire  logic                                  CLK,
  input  wire  logic                                  RESET,
  // apb slave
  input  wire  logic                                  PSEL,
  input  wire  logic                                  PENABLE,
  input  wire  logic                                  PWRITE,
  input  wire  logic [spio_pkg::APB_ADDR_W-1:0]       PADDR,
  input  wire  logic [spio_pkg::APB_DATA_W-1:0]       PWDATA,
  output logic                                        PREADY,
  output logic [spio_pkg::APB_DATA_W-1:0]             PRDATA,
  output logic                                        PSLVERR,
  // general purpose pins
  input  wire  logic [spio_pkg::PIN_COUNT-1:0]        IO_PIN_IN,
  output spio_pkg::spio_pin_drive_t                   IO_PIN_DRIVE
);
  import spio_pkg::*;

  // ==========================================================================
  // address decode

  // maps a byte address to the register it selects
  function automatic spio_sel_t decode_sel(
    input logic [APB_ADDR_W-1:0] addr
  );
    spio_sel_t sel;
    sel = SEL_NONE;
    if (addr == IO_PORT_VALUE_ADDR) begin
      sel = SEL_PORT;
    end else if (addr == IO_PIN_DIRECTION_ADDR) begin
      sel = SEL_DIR;
    end
    return sel;
  endfunction : decode_sel

  // port read value: stored bit for outputs, sampled level for inputs
  function automatic logic [PIN_COUNT-1:0] port_readback(
    input logic [PIN_COUNT-1:0] dir,
    input logic [PIN_COUNT-1:0] stored,
    input logic [PIN_COUNT-1:0] sampled
  );
    return (dir & stored) | (~dir & sampled);
  endfunction : port_readback

  // ==========================================================================
  // state

  spio_state_t state;
  spio_state_t next_state;
  spio_sel_t   sel;
  logic        setup_phase;
  logic        write_access;

  // bus phase qualifiers
  assign sel          = decode_sel(PADDR);
  assign setup_phase  = PSEL & ~PENABLE;
  assign write_access = PSEL & PENABLE & PWRITE;

  // next state of the whole block
  always_comb begin
    next_state = state;
    // two-stage synchroniser on the pin inputs
    next_state.pin_meta = IO_PIN_IN;
    next_state.pin_sync = state.pin_meta;
    // writes take effect in the access phase
    if (write_access) begin
      case (sel)
        SEL_PORT: begin
          // reserved bits 7..6 are not stored
          next_state.port_value =
            PWDATA[PIN_FIELD_MSB:PIN_FIELD_LSB];
        end
        SEL_DIR: begin
          next_state.direction =
            PWDATA[PIN_FIELD_MSB:PIN_FIELD_LSB];
        end
        default: begin
          next_state.port_value = state.port_value;
        end
      endcase
    end
    // read data and error are prepared in the setup phase
    if (setup_phase) begin
      next_state.rdata  = RDATA_ZERO;
      next_state.slverr = 1'b0;
      case (sel)
        SEL_PORT: begin
          if (!PWRITE) begin
            next_state.rdata[PIN_FIELD_MSB:PIN_FIELD_LSB] =
              port_readback(state.direction, state.port_value,
                            state.pin_sync);
          end
        end
        SEL_DIR: begin
          if (!PWRITE) begin
            next_state.rdata[PIN_FIELD_MSB:PIN_FIELD_LSB] =
              state.direction;
          end
        end
        default: begin
          next_state.slverr = 1'b1; // unmapped address
        end
      endcase
    end
  end

  // state register, reset clears every direction bit
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // outputs

  // zero wait state slave
  assign PREADY  = PSEL & PENABLE;
  assign PRDATA  = state.rdata;
  assign PSLVERR = state.slverr & PSEL & PENABLE;

  // pins drive the stored bit where the direction bit is one
  assign IO_PIN_DRIVE.level = state.port_value;
  assign IO_PIN_DRIVE.oe_n  = ~state.direction;

  // ==========================================================================
  // assertions

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // a direction write is held in the direction register one edge later
  property p_dir_write;
    (write_access && sel == SEL_DIR)
      |=> (state.direction == $past(PWDATA[PIN_FIELD_MSB:PIN_FIELD_LSB]));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction register did not take the written value");

  // a port write reaches the pin drivers one edge later
  property p_port_write;
    (write_access && sel == SEL_PORT)
      |=> (IO_PIN_DRIVE.level ==
           $past(PWDATA[PIN_FIELD_MSB:PIN_FIELD_LSB]));
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("port write did not reach the pin level");

  // enables follow the direction bits, low means driving
  property p_dir_enable;
    (IO_PIN_DRIVE.oe_n ^ state.direction) == PIN_ALL_RELEASED;
  endproperty
  a_dir_enable: assert property (p_dir_enable)
    else $error("output enable does not match direction");

  // a direction write of all ones enables every driver next cycle
  property p_out_enable;
    (write_access && sel == SEL_DIR &&
     PWDATA[PIN_FIELD_MSB:PIN_FIELD_LSB] == PIN_ALL_RELEASED)
      |=> (IO_PIN_DRIVE.oe_n == PIN_ALL_ZERO);
  endproperty
  a_out_enable: assert property (p_out_enable)
    else $error("pins not driven after direction set to output");

  // after reset all pins are inputs
  property p_reset_inputs;
    disable iff (1'b0)
    (!RESET && $past(RESET)) |-> (state.direction == PIN_ALL_ZERO &&
                                  IO_PIN_DRIVE.oe_n == PIN_ALL_RELEASED);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("pins not inputs after reset");

  // a direction read returns the direction held at setup
  property p_dir_read;
    (setup_phase && !PWRITE && sel == SEL_DIR)
      ##1 (PSEL && PENABLE)
      |-> (PRDATA[PIN_FIELD_MSB:PIN_FIELD_LSB] == $past(state.direction)
           && PREADY && !PSLVERR);
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction read returned wrong value");

  // a port read mixes stored bits and sampled pin levels
  property p_port_read;
    (setup_phase && !PWRITE && sel == SEL_PORT)
      |=> (PRDATA[PIN_FIELD_MSB:PIN_FIELD_LSB] ==
           (($past(state.direction) & $past(state.port_value)) |
            (~$past(state.direction) & $past(state.pin_sync))));
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("port read did not return the pin levels");

  // a stable input pin shows up in the sampled level within three edges
  property p_pin_sample;
    ((!RESET && $stable(IO_PIN_IN)) [*3])
      |-> (state.pin_sync == $past(IO_PIN_IN, 2));
  endproperty
  a_pin_sample: assert property (p_pin_sample)
    else $error("pin level not sampled after two stages");

  // reserved and upper bits always read as zero
  property p_reserved_zero;
    (PSEL && PENABLE && !PWRITE)
      |-> (PRDATA[APB_DATA_W-1:PIN_FIELD_MSB+1] == '0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved read data bits not zero");

  // an unmapped address answers with an error in its access phase
  property p_unmapped;
    (setup_phase && sel == SEL_NONE) ##1 (PSEL && PENABLE)
      |-> (PSLVERR && PRDATA == RDATA_ZERO);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access did not report an error");

  // the pin level only moves on a port write
  property p_port_hold;
    !(write_access && sel == SEL_PORT)
      |=> $stable(IO_PIN_DRIVE.level);
  endproperty
  a_port_hold: assert property (p_port_hold)
    else $error("pin level changed without a port write");

  // a direction bit keeps its value until software writes it again
  property p_dir_hold;
    !(write_access && sel == SEL_DIR)
      |=> $stable(state.direction);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed without a direction write");

  // read data stands from its setup cycle until the next one
  property p_rdata_stands;
    !setup_phase |=> $stable(PRDATA);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data changed outside a setup cycle");

  // ready and error only show in an access phase
  property p_idle_quiet;
    !(PSEL && PENABLE) |-> (!PREADY && !PSLVERR);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("ready or error raised outside an access phase");

  // a write to an unmapped address leaves both registers alone
  property p_unmapped_write;
    (write_access && sel == SEL_NONE)
      |=> ($stable(state.port_value) && $stable(state.direction));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write changed a register");

  // a mapped address never answers with an error
  property p_mapped_ok;
    (setup_phase && sel != SEL_NONE) ##1 (PSEL && PENABLE)
      |-> !PSLVERR;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped access reported an error");

  // a write transfer carries zero read data
  property p_write_rdata_zero;
    (setup_phase && PWRITE) |=> (PRDATA == RDATA_ZERO);
  endproperty
  a_write_rdata_zero: assert property (p_write_rdata_zero)
    else $error("write transfer returned nonzero read data");

  // after reset the stored port bits are zero
  property p_reset_level;
    disable iff (1'b0)
    (!RESET && $past(RESET)) |-> (IO_PIN_DRIVE.level == PIN_ALL_ZERO);
  endproperty
  a_reset_level: assert property (p_reset_level)
    else $error("pin level not zero after reset");

  // covers of the main scenarios
  c_dir_write: cover property (write_access && sel == SEL_DIR);
  c_port_read_input: cover property (
    setup_phase && !PWRITE && sel == SEL_PORT &&
    state.direction != PIN_ALL_RELEASED);
  c_drive_out: cover property (IO_PIN_DRIVE.oe_n == PIN_ALL_ZERO);
  c_unmapped: cover property (PSLVERR);
  c_port_write_out: cover property (
    write_access && sel == SEL_PORT &&
    state.direction != PIN_ALL_ZERO);

endmodule : spio_top

// *** spio_top_tb.sv ***
// spio_top_tb: self-checking bench for the six-pin port
// assumes: zero-wait apb slave, two-flop pin synchroniser
`timescale 1ns/100ps

module spio_top_tb;
  import spio_pkg::*;
  logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [APB_ADDR_W-1:0] PADDR = '0;
  logic [APB_DATA_W-1:0] PWDATA = '0, PRDATA;
  logic PREADY, PSLVERR;
  logic [PIN_COUNT-1:0] pins, ext = '0, v, p;
  spio_pin_drive_t drv;
  logic [33:0] expq[$];
  logic [33:0] e;
  int fail_count = 0, checked = 0;
  logic [31:0] seed = 32'h4981;

  // ==========================================================================
  // clock, design and far side
  always #10 CLK = ~CLK;
  spio_top dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR), .IO_PIN_IN(pins),
    .IO_PIN_DRIVE(drv));
  spio_ext far (.drive(drv), .ext_level(ext), .pin_level(pins));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; expected {write, slverr, rdata} noted in the queue
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] x);
    expq.push_back({wr, x});
    @(posedge CLK);
    PSEL <= 1; PENABLE <= 0; PWRITE <= wr; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL <= 0; PENABLE <= 0;
  endtask : apb

  // ==========================================================================
  // monitor: compare each completed transfer with the oldest note
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      e = expq.size() ? expq.pop_front() : 34'h3FFFFFFFF;
      if (e[33]) check({PSLVERR, 32'h0}, {e[32], 32'h0});
      else check({PSLVERR, PRDATA}, e[32:0]);
    end
  end

  task automatic end_sim();
    $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    #100us;
    fail_count++;
    end_sim();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge CLK);
    RESET <= 0;
    apb(0, IO_PIN_DIRECTION_ADDR, 0, 33'h0);
    @(posedge CLK);
    check(drv.oe_n, 6'h3F);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      v = PIN_COUNT'(rnd());
      p = PIN_COUNT'(rnd());
      ext <= PIN_COUNT'(rnd());
      // upper bits kept zero by software
      apb(1, IO_PIN_DIRECTION_ADDR, {26'h0, v}, 33'h0);
      apb(1, IO_PORT_VALUE_ADDR, {26'h0, p}, 33'h0);
      apb(0, IO_PIN_DIRECTION_ADDR, 0, {27'h0, v});
      check(drv.oe_n, PIN_COUNT'(~v));
      check(drv.level, p);
      apb(0, IO_PORT_VALUE_ADDR, 0, {27'h0, (p & v) | (ext & ~v)});
    end
    $display("test direction and port done");
    apb(1, 8'hC8, 32'h3F, {1'b1, 32'h0});
    apb(0, 8'hCE, 0, {1'b1, 32'h0});
    check(drv.level, p);
    apb(0, IO_PIN_DIRECTION_ADDR, 0, {27'h0, v});
    $display("test unmapped done");
    @(posedge CLK);
    RESET <= 1;
    repeat (2) @(posedge CLK);
    RESET <= 0;
    @(posedge CLK);
    check(drv.oe_n, 6'h3F);
    apb(0, IO_PIN_DIRECTION_ADDR, 0, 33'h0);
    repeat (2) @(posedge CLK);
    check(expq.size(), 0);
    $display("test second reset done");
    end_sim();
  end
endmodule : spio_top_tb
